// ---- logic/rag_pkg.sv ----
// constants, classes and timing table of the register access gate
`default_nettype none

package rag_pkg;

  // ************************************************************
  // policy classes
  // ************************************************************
  typedef enum logic [3:0] {
    RAG_S1 = 4'h0,
    RAG_S2 = 4'h1,
    RAG_S3 = 4'h2,
    RAG_S4 = 4'h3,
    RAG_S5 = 4'h4,
    RAG_S6 = 4'h5,
    RAG_S7 = 4'h6,
    RAG_P1 = 4'h7,
    RAG_P2 = 4'h8,
    RAG_P3 = 4'h9,
    RAG_P4 = 4'hA,
    RAG_P5 = 4'hB
  } rag_class_t;

  // ************************************************************
  // address map, secure alias
  // ************************************************************
  localparam logic [31:0] ALIAS_BIT = 32'h1000_0000;
  localparam logic [31:0] LPT_LO = 32'h4022_0000;
  localparam logic [31:0] LPT_HI = 32'h4022_01FF;
  localparam logic [31:0] USB_A_LO = 32'h4035_1000;
  localparam logic [31:0] USB_A_HI = 32'h4035_115F;
  localparam logic [31:0] USB_B_LO = 32'h4035_1160;
  localparam logic [31:0] USB_B_HI = 32'h4035_1167;
  localparam logic [31:0] USB_C_LO = 32'h4035_1168;
  localparam logic [31:0] USB_C_HI = 32'h4035_116F;
  localparam logic [31:0] PWM_LO = 32'h4032_2000;
  localparam logic [31:0] PWM_HI = 32'h4032_3F0F;
  localparam logic [31:0] PFS_LO = 32'h4040_0800;
  localparam logic [31:0] PFS_HI = 32'h4040_0FFF;

  // ************************************************************
  // cycle counts at equal clocks
  // ************************************************************
  localparam logic [7:0] LPT_RD = 8'h06;
  localparam logic [7:0] LPT_WR = 8'h41;
  localparam logic [7:0] USB_RD_ADD = 8'h04;
  localparam logic [7:0] USB_WR_ADD = 8'h03;
  localparam logic [7:0] USB_LONG_WR = 8'h82;
  localparam logic [7:0] USB_C_RD = 8'h08;
  localparam logic [7:0] PWM_RD = 8'h09;
  localparam logic [7:0] PWM_WR = 8'h06;
  localparam logic [7:0] PFS_RD = 8'h08;
  localparam logic [7:0] PFS_WR = 8'h02;
  localparam logic [7:0] DFLT_RD = 8'h04;
  localparam logic [7:0] DFLT_WR = 8'h03;

  // ************************************************************
  // clock units of a region
  // ************************************************************
  typedef enum logic [1:0] {
    RAG_U_SYS = 2'h0,
    RAG_U_FAST = 2'h1,
    RAG_U_SLOW = 2'h2
  } rag_unit_t;

  localparam logic [3:0] RATIO_RST = 4'h1;
  localparam logic [7:0] CNT_RST = 8'h00;

endpackage : rag_pkg

`default_nettype wire

// ---- logic/rag_clk_div.sv ----
// divider giving a one-cycle peripheral clock enable
`default_nettype none

module rag_clk_div (
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // synchronised reset, active low
  input wire logic [3:0] ratio_i, // system cycles per peripheral cycle, 0 read as 1
  output logic tick_o // one-cycle enable pulse
);

  logic [3:0] cnt_q;
  logic last;

  assign last = (cnt_q + 4'h1 >= ratio_i);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_q <= last ? 4'h0 : cnt_q + 4'h1;
      tick_o <= last;
    end
  end

endmodule : rag_clk_div

`default_nettype wire

// ---- logic/rag_top.sv ----
// register access gate: security and privilege filter plus access timing
`default_nettype none

module rag_top #(
  parameter int WAIT_W = 4 // width of the hs usb bus wait count
) (
  input wire logic clock_i, // system clock, 10 MHz
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic [3:0] fast_ratio_i, // system / fast peripheral clock ratio
  input wire logic [3:0] slow_ratio_i, // system / slow peripheral clock ratio
  input wire logic [WAIT_W-1:0] bus_wait_count_i, // wait count from the bus wait register
  input wire logic req_valid_i, // access request
  input wire logic req_write_i, // 1 write, 0 read
  input wire logic [31:0] req_addr_i, // byte address, either alias
  input wire logic [31:0] req_wdata_i, // write data
  input wire logic req_secure_i, // access is secure
  input wire logic req_priv_i, // access is privileged
  input wire logic [3:0] req_class_i, // policy class of the addressed register
  input wire logic attr_secure_i, // configured security attribution is secure
  input wire logic attr_priv_i, // configured privilege attribution is privileged
  output logic req_ready_o, // gate idle, request may be taken
  output logic rsp_valid_o, // response pulse
  output logic [31:0] rsp_rdata_o, // read data, zero when refused
  output logic rsp_error_o, // security or privilege access error
  output logic per_valid_o, // peripheral strobe pulse
  output logic per_write_o, // peripheral strobe is a write
  output logic [31:0] per_addr_o, // peripheral address
  output logic [31:0] per_wdata_o, // peripheral write data
  input wire logic [31:0] per_rdata_i // peripheral read data during strobe
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ************************************************************
  // peripheral clock enables
  // ************************************************************
  logic fast_tick;
  logic slow_tick;

  rag_clk_div u_fast_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .ratio_i(fast_ratio_i),
    .tick_o(fast_tick)
  );

  rag_clk_div u_slow_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .ratio_i(slow_ratio_i),
    .tick_o(slow_tick)
  );

  // ************************************************************
  // policy decision, returns {allow, error}
  // ************************************************************
  function automatic logic [1:0] decide(input logic [3:0] cls, input logic wr, input logic sec,
                                        input logic priv, input logic asec, input logic apriv);
    logic match;
    logic [1:0] r;
    match = (sec == asec);
    r = 2'h1;
    case (cls)
      rag_pkg::RAG_S1: r = {(!wr) || sec, 1'b0};
      rag_pkg::RAG_S2: r = {(!wr) || match, 1'b0};
      rag_pkg::RAG_S3: r = {match, !match};
      rag_pkg::RAG_S4: r = {match, 1'b0};
      rag_pkg::RAG_S5: r = 2'h2;
      rag_pkg::RAG_S6: r = {sec, !sec};
      rag_pkg::RAG_S7: r = {!sec, sec};
      rag_pkg::RAG_P1: r = {(!wr) || priv, 1'b0};
      rag_pkg::RAG_P2: r = {priv, !priv};
      rag_pkg::RAG_P3: r = apriv ? {priv, !priv} : 2'h2;
      rag_pkg::RAG_P4: r = apriv ? {priv, 1'b0} : 2'h2;
      rag_pkg::RAG_P5: r = 2'h2;
      default: r = 2'h1;
    endcase
    return r;
  endfunction : decide

  // ************************************************************
  // address window test
  // ************************************************************
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // ************************************************************
  // region timing lookup
  // ************************************************************
  logic [31:0] sec_addr;
  logic [7:0] wait_ext;
  rag_pkg::rag_unit_t unit;
  logic [7:0] base_cnt;

  // both aliases fold to the secure address before lookup
  assign sec_addr = req_addr_i & ~rag_pkg::ALIAS_BIT;
  assign wait_ext = 8'(bus_wait_count_i);

  always_comb begin
    unit = rag_pkg::RAG_U_SLOW;
    base_cnt = req_write_i ? rag_pkg::DFLT_WR : rag_pkg::DFLT_RD;
    if (in_range(sec_addr, rag_pkg::LPT_LO, rag_pkg::LPT_HI)) begin
      base_cnt = req_write_i ? rag_pkg::LPT_WR : rag_pkg::LPT_RD;
    end else if (in_range(sec_addr, rag_pkg::USB_A_LO, rag_pkg::USB_A_HI)) begin
      unit = rag_pkg::RAG_U_FAST;
      base_cnt = wait_ext + (req_write_i ? rag_pkg::USB_WR_ADD : rag_pkg::USB_RD_ADD);
    end else if (in_range(sec_addr, rag_pkg::USB_B_LO, rag_pkg::USB_B_HI)) begin
      unit = rag_pkg::RAG_U_FAST;
      base_cnt = req_write_i ? rag_pkg::USB_LONG_WR : wait_ext + rag_pkg::USB_RD_ADD;
    end else if (in_range(sec_addr, rag_pkg::USB_C_LO, rag_pkg::USB_C_HI)) begin
      unit = rag_pkg::RAG_U_FAST;
      base_cnt = req_write_i ? rag_pkg::USB_LONG_WR : rag_pkg::USB_C_RD;
    end else if (in_range(sec_addr, rag_pkg::PWM_LO, rag_pkg::PWM_HI)) begin
      unit = rag_pkg::RAG_U_FAST;
      base_cnt = req_write_i ? rag_pkg::PWM_WR : rag_pkg::PWM_RD;
    end else if (in_range(sec_addr, rag_pkg::PFS_LO, rag_pkg::PFS_HI)) begin
      unit = rag_pkg::RAG_U_SYS;
      base_cnt = req_write_i ? rag_pkg::PFS_WR : rag_pkg::PFS_RD;
    end
  end

  // ************************************************************
  // peripheral clock synchronisation
  // ************************************************************
  // equal clocks count system cycles directly; a faster system clock waits
  // one count less in peripheral ticks, the partial first tick acting as the
  // synchronisation stage, so fractional phases land inside the min..max span
  logic [3:0] sel_ratio;
  logic sync_mode;
  logic [7:0] load_cnt;

  always_comb begin
    sel_ratio = (unit == rag_pkg::RAG_U_FAST) ? fast_ratio_i : slow_ratio_i;
    sync_mode = (unit != rag_pkg::RAG_U_SYS) && (sel_ratio > 4'h1);
    load_cnt = base_cnt;
    if (sync_mode && (base_cnt > 8'h01)) begin
      load_cnt = base_cnt - 8'h01;
    end
    if (load_cnt == 8'h00) begin
      load_cnt = 8'h01;
    end
  end

  // ************************************************************
  // access sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    RAG_IDLE = 2'h0,
    RAG_COUNT = 2'h1,
    RAG_STROBE = 2'h2,
    RAG_RESP = 2'h3
  } rag_state_t;

  rag_state_t state_q;
  logic [7:0] cnt_q;
  logic sync_q;
  rag_pkg::rag_unit_t unit_q;
  logic allow_q;
  logic err_q;
  logic tick;
  logic take;
  logic [1:0] verdict;

  // masters keep off secure addresses when non-secure and off reserved holes
  assign take = req_valid_i && req_ready_o;
  assign verdict = decide(req_class_i, req_write_i, req_secure_i, req_priv_i, attr_secure_i, attr_priv_i);

  always_comb begin
    tick = 1'b1;
    if (sync_q) begin
      tick = (unit_q == rag_pkg::RAG_U_FAST) ? fast_tick : slow_tick;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RAG_IDLE;
      cnt_q <= rag_pkg::CNT_RST;
      sync_q <= 1'b0;
      unit_q <= rag_pkg::RAG_U_SYS;
      req_ready_o <= 1'b0;
    end else begin
      case (state_q)
        RAG_IDLE: begin
          req_ready_o <= 1'b1;
          if (take) begin
            state_q <= RAG_COUNT;
            cnt_q <= load_cnt;
            sync_q <= sync_mode;
            unit_q <= unit;
            req_ready_o <= 1'b0;
          end
        end
        RAG_COUNT: begin
          // counts assume no bufferable write and no competing master
          if (tick) begin
            if (cnt_q == 8'h01) begin
              state_q <= RAG_STROBE;
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
        end
        RAG_STROBE: state_q <= RAG_RESP;
        RAG_RESP: begin
          state_q <= RAG_IDLE;
          req_ready_o <= 1'b1;
        end
        default: state_q <= RAG_IDLE;
      endcase
    end
  end

  // ************************************************************
  // latched verdict
  // ************************************************************
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      allow_q <= 1'b0;
      err_q <= 1'b0;
    end else if (take) begin
      allow_q <= verdict[1];
      err_q <= verdict[0];
    end
  end

  // ************************************************************
  // latched peripheral request
  // ************************************************************
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      per_write_o <= 1'b0;
      per_addr_o <= 32'h0000_0000;
      per_wdata_o <= 32'h0000_0000;
    end else if (take) begin
      per_write_o <= req_write_i;
      per_addr_o <= req_addr_i;
      per_wdata_o <= req_wdata_i;
    end
  end

  // ************************************************************
  // peripheral strobe
  // ************************************************************
  logic strobe_next;

  assign strobe_next = (state_q == RAG_COUNT) && tick && (cnt_q == 8'h01);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      per_valid_o <= 1'b0;
    end else begin
      // refused accesses never reach the peripheral
      per_valid_o <= strobe_next && allow_q;
    end
  end

  // ************************************************************
  // response to the master
  // ************************************************************
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_o <= 1'b0;
    end else begin
      rsp_valid_o <= (state_q == RAG_STROBE);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_rdata_o <= 32'h0000_0000;
      rsp_error_o <= 1'b0;
    end else if (state_q == RAG_STROBE) begin
      rsp_rdata_o <= (allow_q && !per_write_o) ? per_rdata_i : 32'h0000_0000;
      rsp_error_o <= err_q;
    end else begin
      rsp_error_o <= 1'b0;
    end
  end

endmodule : rag_top

`default_nettype wire

// ---- testbench/rag_per_model.sv ----
// peripheral register block model behind the gate
`default_nettype none

module rag_per_model (
  input wire logic clock_i, // system clock
  input wire logic arst_n_i, // reset, active low
  input wire logic per_valid_i, // strobe
  input wire logic per_write_i, // strobe is a write
  input wire logic [31:0] per_addr_i, // address
  input wire logic [31:0] per_wdata_i, // write data
  output logic [31:0] per_rdata_o // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem_q [16];
  logic [31:0] last_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= 32'hC0DE_0000 | 32'(i);
      end
      last_q <= 32'h0;
    end else if (per_valid_i) begin
      last_q <= per_rdata_o;
      if (per_write_i) begin
        mem_q[per_addr_i[5:2]] <= per_wdata_i;
      end
    end
  end
  // not selected: inverse of the last answer, never a stale copy
  assign per_rdata_o = per_valid_i ? mem_q[per_addr_i[5:2]] : ~last_q;
endmodule : rag_per_model

`default_nettype wire

// ---- testbench/rag_top_assertions.sv ----
// assertion checker of the register access gate
`default_nettype none

module rag_top_checker #(
  parameter int WAIT_W = 4 // bus wait width
) (
  input wire logic clock_i, // system clock
  input wire logic arst_n_i, // reset, active low
  input wire logic [3:0] fast_ratio_i, // fast ratio
  input wire logic req_valid_i, // request
  input wire logic req_write_i, // write
  input wire logic [31:0] req_addr_i, // address
  input wire logic req_secure_i, // secure
  input wire logic [3:0] req_class_i, // class
  input wire logic req_ready_o, // ready
  input wire logic rsp_valid_o, // response
  input wire logic [31:0] rsp_rdata_o, // read data
  input wire logic rsp_error_o, // error
  input wire logic per_valid_o // strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************
  // helpers
  // ************
  logic take;
  logic [31:0] base;
  logic [3:0] cls_q;
  logic sec_q;
  logic in_pfs;
  logic in_pwm;
  assign take = req_valid_i & req_ready_o;
  assign base = req_addr_i & ~rag_pkg::ALIAS_BIT;
  assign in_pfs = (base >= rag_pkg::PFS_LO) && (base <= rag_pkg::PFS_HI);
  assign in_pwm = (base >= rag_pkg::PWM_LO) && (base <= rag_pkg::PWM_HI);
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cls_q <= 4'h0;
      sec_q <= 1'b0;
    end else if (take) begin
      cls_q <= req_class_i;
      sec_q <= req_secure_i;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  AST_RSP_PULSE: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("response longer than one cycle");
  AST_STROBE_THEN_RSP: assert property (per_valid_o |=> rsp_valid_o && !rsp_error_o)
    else $error("allowed access not answered cleanly");
  AST_ERR_ZERO: assert property (rsp_error_o |-> rsp_valid_o && rsp_rdata_o == 32'h0)
    else $error("error without zero data or response");
  AST_TAKE_BUSY: assert property (take |=> !req_ready_o [*3])
    else $error("ready during access");
  AST_PFS_RD: assert property (take && !req_write_i && in_pfs |-> ##10 rsp_valid_o)
    else $error("pin function read timing");
  AST_PFS_WR: assert property (take && req_write_i && in_pfs |-> ##4 rsp_valid_o)
    else $error("pin function write timing");
  AST_PWM_RD: assert property (take && !req_write_i && fast_ratio_i <= 4'h1 && in_pwm |-> ##11 rsp_valid_o)
    else $error("pwm read timing");
  AST_S1_SILENT: assert property (rsp_valid_o && cls_q == 4'h0 |-> !rsp_error_o)
    else $error("secure-write-only class raised error");
  AST_S6_ERR: assert property (rsp_valid_o && cls_q == 4'h5 |-> rsp_error_o == !sec_q)
    else $error("secure-only class error wrong");
  AST_S7_ERR: assert property (rsp_valid_o && cls_q == 4'h6 |-> rsp_error_o == sec_q)
    else $error("non-secure-only class error wrong");
  COV_ERR: cover property (rsp_error_o);
  COV_STROBE: cover property (per_valid_o);
  COV_PFS: cover property (take && base >= rag_pkg::PFS_LO && base <= rag_pkg::PFS_HI);
endmodule : rag_top_checker

bind rag_top rag_top_checker #(.WAIT_W(WAIT_W)) rag_top_checker_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .fast_ratio_i(fast_ratio_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
  .req_secure_i(req_secure_i), .req_class_i(req_class_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
  .rsp_rdata_o(rsp_rdata_o), .rsp_error_o(rsp_error_o), .per_valid_o(per_valid_o));

`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench of the register access gate
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] DFLT = 32'h4020_1000;
  logic clock_i, arst_n_i, req_valid_i, req_write_i, req_secure_i, req_priv_i, attr_secure_i, attr_priv_i;
  logic [3:0] fast_ratio_i, slow_ratio_i, bus_wait_count_i, req_class_i;
  logic [31:0] req_addr_i, req_wdata_i, per_rdata_i, rsp_rdata_o, per_addr_o, per_wdata_o;
  logic req_ready_o, rsp_valid_o, rsp_error_o, per_valid_o, per_write_o;
  logic [31:0] shadow [16];
  int n_fail, checks_done;

  rag_top #(.WAIT_W(4)) rag_top_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .fast_ratio_i(fast_ratio_i),
    .slow_ratio_i(slow_ratio_i), .bus_wait_count_i(bus_wait_count_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_secure_i(req_secure_i),
    .req_priv_i(req_priv_i), .req_class_i(req_class_i), .attr_secure_i(attr_secure_i), .attr_priv_i(attr_priv_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_error_o(rsp_error_o),
    .per_valid_o(per_valid_o), .per_write_o(per_write_o), .per_addr_o(per_addr_o), .per_wdata_o(per_wdata_o),
    .per_rdata_i(per_rdata_i));
  rag_per_model rag_per_model_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .per_valid_i(per_valid_o),
    .per_write_i(per_write_o), .per_addr_i(per_addr_o), .per_wdata_i(per_wdata_o), .per_rdata_o(per_rdata_i));

  // ************
  // helpers
  // ************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // returns {allowed, error}
  function automatic logic [1:0] policy(input logic [3:0] c, input logic wr, s, p, as, ap);
    case (c)
      4'h0: return {!wr || s, 1'b0};
      4'h1: return {!wr || s == as, 1'b0};
      4'h2: return {s == as, s != as};
      4'h3: return {s == as, 1'b0};
      4'h4: return 2'b10;
      4'h5: return {s, !s};
      4'h6: return {!s, s};
      4'h7: return {!wr || p, 1'b0};
      4'h8: return {p, !p};
      4'h9: return {p || !ap, !p && ap};
      4'hA: return {p || !ap, 1'b0};
      4'hB: return 2'b10;
      default: return 2'b01;
    endcase
  endfunction : policy

  task automatic access(input logic wr, input logic [31:0] addr, input logic s, p, input logic [3:0] c,
      input logic as, ap, input int lo, input int hi);
    logic ok, er, seen;
    logic [31:0] wd;
    int n;
    {ok, er} = policy(c, wr, s, p, as, ap);
    wd = {addr[15:0], 12'h5A0, c};
    seen = 1'b0;
    n = 0;
    @(posedge clock_i);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i <= addr;
    req_wdata_i <= wd;
    req_secure_i <= s;
    req_priv_i <= p;
    req_class_i <= c;
    attr_secure_i <= as;
    attr_priv_i <= ap;
    for (int i = 0; i < 20 && req_ready_o !== 1'b1; i++) @(negedge clock_i);
    @(posedge clock_i);
    req_valid_i <= 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 300) begin
      @(negedge clock_i);
      n++;
      if (per_valid_o === 1'b1) begin
        seen = 1'b1;
        check("strobe addr", addr, per_addr_o);
        check("strobe kind", {31'h0, wr}, {31'h0, per_write_o});
        if (wr) check("strobe data", wd, per_wdata_o);
      end
    end
    checks_done++;
    if (n < lo + 2 || n > hi + 2) begin
      n_fail++;
      $display("MISMATCH latency expected %0d to %0d seen %0d", lo + 2, hi + 2, n);
    end
    check("error", {31'h0, er}, {31'h0, rsp_error_o});
    check("strobe", {31'h0, ok}, {31'h0, seen});
    if (!wr) check("read data", ok ? shadow[addr[5:2]] : 32'h0, rsp_rdata_o);
    else if (ok) shadow[addr[5:2]] = wd;
  endtask : access

  // ************
  // scenarios
  // ************
  task automatic t_policy();
    logic [31:0] addr;
    for (int c = 0; c < 13; c++) begin
      for (int k = 0; k < 32; k++) begin
        // mapped register addresses only, non-secure masters on the non-secure alias
        addr = (DFLT | (k[1] ? 32'h0 : rag_pkg::ALIAS_BIT)) + 32'(k[4:1] * 4);
        access(k[0], addr, k[1], k[2], c[3:0], k[3], k[4], k[0] ? 3 : 4, k[0] ? 3 : 4);
      end
    end
    $display("test policy done");
  endtask : t_policy

  // unrestricted class; the non-secure alias is reached by a non-secure master
  task automatic timed(input logic wr, input logic [31:0] addr, input int lo, input int hi);
    access(wr, addr, !addr[28], 1'b1, 4'h4, !addr[28], 1'b1, lo, hi);
  endtask : timed

  task automatic t_timing_equal();
    timed(1'b0, 32'h4022_0000, 6, 6);
    timed(1'b1, 32'h4022_0004, 65, 65);
    timed(1'b0, 32'h4035_1000, 9, 9);
    timed(1'b1, 32'h4035_1004, 8, 8);
    timed(1'b0, 32'h4035_1160, 9, 9);
    timed(1'b1, 32'h4035_1164, 130, 130);
    timed(1'b0, 32'h4035_1168, 8, 8);
    timed(1'b1, 32'h4035_116C, 130, 130);
    timed(1'b0, 32'h4032_2000, 9, 9);
    timed(1'b1, 32'h4032_2004, 6, 6);
    timed(1'b0, 32'h5032_2000, 9, 9);
    timed(1'b0, 32'h4040_0800, 8, 8);
    timed(1'b1, 32'h5040_0804, 2, 2);
    $display("test equal clock timing done");
  endtask : t_timing_equal

  task automatic t_timing_fast();
    @(posedge clock_i);
    fast_ratio_i <= 4'h2;
    slow_ratio_i <= 4'h3;
    timed(1'b0, 32'h4022_0008, 12, 18);
    timed(1'b1, 32'h4022_000C, 189, 195);
    timed(1'b0, 32'h4032_2008, 14, 18);
    timed(1'b1, 32'h4032_200C, 8, 12);
    timed(1'b0, 32'h5032_2008, 14, 18);
    timed(1'b0, 32'h4035_1008, 14, 18);
    timed(1'b0, DFLT + 32'h4, 6, 12);
    timed(1'b0, 32'h4040_0808, 8, 8);
    timed(1'b1, 32'h4040_080C, 2, 2);
    $display("test faster clock timing done");
  endtask : t_timing_fast

  task automatic t_reset();
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    @(negedge clock_i);
    check("ready in reset", 32'h0, {31'h0, req_ready_o});
    check("addr in reset", 32'h0, per_addr_o);
    for (int i = 0; i < 16; i++) shadow[i] = 32'hC0DE_0000 | 32'(i);
    @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (2) @(negedge clock_i);
    check("ready after release", 32'h0, {31'h0, req_ready_o});
    timed(1'b0, DFLT, 6, 12);
    $display("test reset done");
  endtask : t_reset

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  initial begin
    #2_000_000;
    n_fail++;
    give_verdict();
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    for (int i = 0; i < 16; i++) shadow[i] = 32'hC0DE_0000 | 32'(i);
    {arst_n_i, req_valid_i, req_write_i, req_secure_i, req_priv_i, attr_secure_i, attr_priv_i} = '0;
    {fast_ratio_i, slow_ratio_i, bus_wait_count_i, req_class_i} = {4'h1, 4'h1, 4'h5, 4'h0};
    {req_addr_i, req_wdata_i} = '0;
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_policy();
    t_timing_equal();
    t_timing_fast();
    t_reset();
    give_verdict();
  end
endmodule : tb

`default_nettype wire
